// >>> verilog/fep_pipe.sv
/*
 * four-phase fetch/execute pipeline controller with prefetch, branch flush and skip idle.
 * assumes program memory returns the word for pm_addr combinationally, sampled at the end of phase one.
 */
`timescale 1ns/100ps
module fep_pipe import fep_pkg::*; #(
	parameter int PC_W = FEP_PC_W_DEF
) (
	// clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   nrst,
	// oscillator tick enables and source select
	input  wire logic                   crystal_oscillator,
	input  wire logic                   fast_internal_rc,
	input  wire logic                   slow_internal_rc,
	input  wire fep_src_type            clk_src,
	// program memory
	output logic [PC_W-1:0]             pm_addr,
	output logic                        pm_rd,
	input  wire logic [FEP_INSTR_W-1:0] pm_data,
	// core state
	output fep_phase_type               phase,
	output logic [FEP_DATA_W-1:0]       acc,
	output fep_status_type              status
);

	// ============================================================
	// elaboration check
	if (PC_W <= FEP_PAGE_W || PC_W > FEP_OP_LSB) begin : g_bad_pc_w
		$error("PC_W must exceed the page width and fit the address field");
	end

	// ============================================================
	// system tick selection
	logic sys_tick;
	logic cyc_end;

	always_comb begin
		unique case (clk_src)
			FEP_SRC_CRYSTAL: sys_tick = crystal_oscillator;
			FEP_SRC_FAST_RC: sys_tick = fast_internal_rc;
			FEP_SRC_SLOW_RC: sys_tick = slow_internal_rc;
			default:         sys_tick = 1'b0;
		endcase
	end

	assign cyc_end = sys_tick & phase.decode_execute_phases[2];

	// ============================================================
	// phase generator
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			phase <= fep_phase_type'(FEP_PH_RESET);
		end else if (sys_tick) begin
			phase <= fep_phase_type'({phase[2:0], phase[3]});
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pm_rd <= 1'b1;
		end else if (sys_tick) begin
			pm_rd <= phase[3];
		end
	end

	// ============================================================
	// decode of the executing word
	fep_state_type             state;
	logic [PC_W-1:0]           pc;
	logic [FEP_INSTR_W-1:0]    fetched;
	logic [FEP_INSTR_W-1:0]    ir;
	logic [3:0]                op;
	logic                      exec;
	logic                      is_alu;
	logic                      is_jmp;
	logic                      skip_met;
	logic                      is_pclw;
	logic                      redirect;
	logic [PC_W-1:0]           target;
	logic [PC_W-1:0]           next_pc;
	logic [PC_W-1:0]           next_addr;
	fep_state_type             next_state;
	logic [FEP_DATA_W-1:0]     alu_res;
	logic                      alu_carry;
	logic                      alu_zero;

	assign op       = ir[FEP_OP_MSB:FEP_OP_LSB];
	assign exec     = (state == FEP_ST_EXEC);
	assign is_alu   = exec && (op == FEP_OP_ALU);
	assign is_jmp   = exec && (op == FEP_OP_JMP || op == FEP_OP_CALL);
	assign is_pclw  = exec && (op == FEP_OP_PCLW);
	assign skip_met = exec && (op == FEP_OP_SKZ) && (acc == '0);
	assign redirect = is_jmp || is_pclw;

	always_comb begin
		if (is_pclw) begin
			target = {pm_addr[PC_W-1:FEP_PAGE_W], acc};
		end else begin
			target = ir[PC_W-1:0];
		end
		if (redirect) begin
			next_addr  = target;
			next_state = FEP_ST_FLUSH;
		end else begin
			next_addr  = pc;
			next_state = skip_met ? FEP_ST_IDLE : FEP_ST_EXEC;
		end
		next_pc = next_addr + {{(PC_W-1){1'b0}}, 1'b1};
	end

	fep_alu u_alu (
		.fn     (fep_alu_fn_type'(ir[FEP_FN_MSB:FEP_FN_LSB])),
		.a      (acc),
		.b      (ir[FEP_IMM_MSB:FEP_IMM_LSB]),
		.result (alu_res),
		.carry  (alu_carry),
		.zero   (alu_zero)
	);

	// ============================================================
	// fetch latch, end of phase one
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			fetched <= FEP_INSTR_RESET;
		end else if (sys_tick && phase.phase_one_clock) begin
			fetched <= pm_data;
		end
	end

	// ============================================================
	// cycle boundary: pc, fetch address, pipeline state
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pc      <= {{(PC_W-1){1'b0}}, 1'b1};
			pm_addr <= '0;
			state   <= FEP_ST_FETCH_ONLY;
			ir      <= FEP_INSTR_RESET;
		end else if (cyc_end) begin
			pc      <= next_pc;
			pm_addr <= next_addr;
			state   <= next_state;
			ir      <= fetched;
		end
	end

	// ============================================================
	// execute write-back at the end of phase four
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			acc <= FEP_ACC_RESET;
		end else if (cyc_end && is_alu) begin
			acc <= alu_res;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			status <= '0;
		end else begin
			status.retire    <= cyc_end && exec;
			status.branch    <= cyc_end && redirect;
			status.skip_idle <= cyc_end && skip_met;
			if (cyc_end && is_alu) begin
				status.carry <= alu_carry;
				status.zero  <= alu_zero;
			end
		end
	end

	// ============================================================
	// assertions
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	phase_onehot_a: assert property ($onehot(phase))
		else $error("phase clocks not one-hot");
	phase_order_a: assert property (sys_tick && phase.phase_one_clock |=> phase.decode_execute_phases[0])
		else $error("phase two does not follow phase one");
	cycle_wrap_a: assert property (cyc_end |=> phase.phase_one_clock && pm_rd)
		else $error("cycle did not wrap to phase one");
	pc_increment_a: assert property (cyc_end |=> pc == pm_addr + {{(PC_W-1){1'b0}}, 1'b1})
		else $error("pc not one ahead of fetch address");
	fetch_advance_a: assert property (cyc_end && !redirect |=>
		pm_addr == $past(pm_addr) + {{(PC_W-1){1'b0}}, 1'b1})
		else $error("fetch address did not advance by one");
	fetch_phase_a: assert property (pm_rd == phase.phase_one_clock)
		else $error("fetch strobe outside phase one");
	exec_phase_a: assert property (!$stable(acc) |-> $past(phase.decode_execute_phases[2]) && $past(exec))
		else $error("accumulator written outside execute");
	retire_rate_a: assert property (cyc_end && exec |=> status.retire)
		else $error("executed word did not retire");
	branch_flush_a: assert property (cyc_end && redirect |=> state == FEP_ST_FLUSH && pm_addr == $past(target))
		else $error("branch did not flush to target");
	flush_noexec_a: assert property (cyc_end && state == FEP_ST_FLUSH |=> !status.retire && $stable(acc))
		else $error("flush cycle executed");
	skip_idle_a: assert property (cyc_end && skip_met |=> state == FEP_ST_IDLE ##0 status.skip_idle)
		else $error("skip did not idle");
	pcl_page_a: assert property (cyc_end && is_pclw |=>
		pm_addr[PC_W-1:FEP_PAGE_W] == $past(pm_addr[PC_W-1:FEP_PAGE_W]) && state == FEP_ST_FLUSH)
		else $error("pc low write left the page");
	alu_zero_a: assert property (cyc_end && is_alu |=> status.zero == (acc == '0))
		else $error("zero flag disagrees with accumulator");
	reset_fetch_a: assert property (state == FEP_ST_FETCH_ONLY |-> !status.retire && $stable(acc))
		else $error("first cycle executed");
	idle_noexec_a: assert property (cyc_end && state == FEP_ST_IDLE |=> !status.retire && $stable(acc))
		else $error("skipped word executed");
	reset_exit_a: assert property (cyc_end && state == FEP_ST_FETCH_ONLY |=> state == FEP_ST_EXEC)
		else $error("first fetch cycle did not lead to execute");
	phase_hold_a: assert property (!sys_tick |=> $stable(phase))
		else $error("phase moved without a tick");
	fetch_hold_a: assert property (!cyc_end |=> $stable(pm_addr))
		else $error("fetch address moved inside a cycle");
	retire_pulse_a: assert property (status.retire |=> !status.retire)
		else $error("retire pulse longer than one clock");
	flag_hold_a: assert property (!(cyc_end && is_alu) |=> $stable(status.carry) && $stable(status.zero))
		else $error("alu flags changed without an alu op");

	// ============================================================
	// scenario covers

	branch_c: cover property (cyc_end && is_jmp);
	skip_c:   cover property (cyc_end && skip_met);
	pclw_c:   cover property (cyc_end && is_pclw);
	retire_c: cover property (status.retire [*1] ##1 !status.retire [*3] ##1 status.retire);

endmodule

// >>> verilog/fep_pkg.sv
/*
 * shared constants, types and encodings of the four-phase fetch/execute pipeline.
 * assumes one system clock with oscillator sources arriving as one-cycle tick enables.
 */
// ============================================================
// Contract
// - four non-overlapping phase clocks repeat in fixed order every instruction cycle.
// - pc increments at start of phase one; next word fetched during phase one.
// - decode and execute happen during phases two, three and four.
// - one pass through the four phases is exactly one instruction cycle.
// - fetch overlaps execution; ordinary instructions retire one per cycle.
// - any pc-changing instruction takes two instruction cycles.
// - branch: first cycle obtains target, second fetches it while flushing the prefetch.
// - an eight-bit alu performs arithmetic, logic, rotate, inc, dec, branch decisions; the skz decision tests acc == 0 in fep_pipe, not in the alu.
// - system clock selectable from crystal, fast rc or slow rc source.
// - a met skip discards the prefetched word and runs an idle cycle.
// - writing pc low byte branches within the current 256-word page, one idle cycle.
package fep_pkg;

	// ============================================================
	// widths
	localparam int FEP_PC_W_DEF = 11;
	localparam int FEP_PAGE_W   = 8;
	localparam int FEP_DATA_W   = 8;
	localparam int FEP_INSTR_W  = 16;

	// ============================================================
	// instruction fields
	localparam int FEP_OP_MSB  = 15;
	localparam int FEP_OP_LSB  = 12;
	localparam int FEP_FN_MSB  = 11;
	localparam int FEP_FN_LSB  = 8;
	localparam int FEP_IMM_MSB = 7;
	localparam int FEP_IMM_LSB = 0;

	localparam logic [3:0] FEP_OP_NOP  = 4'h0;
	localparam logic [3:0] FEP_OP_ALU  = 4'h1;
	localparam logic [3:0] FEP_OP_JMP  = 4'h2;
	localparam logic [3:0] FEP_OP_CALL = 4'h3;
	localparam logic [3:0] FEP_OP_SKZ  = 4'h4;
	localparam logic [3:0] FEP_OP_PCLW = 4'h5;

	typedef enum logic [3:0] {
		FEP_FN_ADD, FEP_FN_SUB, FEP_FN_AND, FEP_FN_OR, FEP_FN_XOR, FEP_FN_CPL,
		FEP_FN_RR, FEP_FN_RL, FEP_FN_INC, FEP_FN_DEC, FEP_FN_PASS
	} fep_alu_fn_type;

	// ============================================================
	// clock sources, phases, pipeline states
	typedef enum logic [1:0] {FEP_SRC_CRYSTAL, FEP_SRC_FAST_RC, FEP_SRC_SLOW_RC} fep_src_type;

	typedef struct packed {
		logic [2:0] decode_execute_phases;
		logic       phase_one_clock;
	} fep_phase_type;

	localparam logic [3:0] FEP_PH_RESET = 4'h1;

	typedef enum logic [1:0] {FEP_ST_FETCH_ONLY, FEP_ST_EXEC, FEP_ST_FLUSH, FEP_ST_IDLE} fep_state_type;

	typedef struct packed {
		logic retire;
		logic branch;
		logic skip_idle;
		logic carry;
		logic zero;
	} fep_status_type;

	localparam logic [FEP_DATA_W-1:0]  FEP_ACC_RESET   = 8'h00;
	localparam logic [FEP_INSTR_W-1:0] FEP_INSTR_RESET = 16'h0000;

endpackage

// >>> verilog/fep_alu.sv
/*
 * eight-bit combinational alu of the core.
 * assumes operands are stable during the execute phases of the cycle.
 */
`timescale 1ns/100ps
module fep_alu import fep_pkg::*; (
	// operation
	input  wire fep_alu_fn_type        fn,
	// operands
	input  wire logic [FEP_DATA_W-1:0] a,
	input  wire logic [FEP_DATA_W-1:0] b,
	// result
	output logic [FEP_DATA_W-1:0]      result,
	output logic                       carry,
	output logic                       zero
);

	// ============================================================
	// datapath
	logic [FEP_DATA_W:0] wide;

	always_comb begin
		wide = {1'b0, a};
		unique case (fn)
			FEP_FN_ADD:  wide = {1'b0, a} + {1'b0, b};
			FEP_FN_SUB:  wide = {1'b0, a} - {1'b0, b};
			FEP_FN_AND:  wide = {1'b0, a & b};
			FEP_FN_OR:   wide = {1'b0, a | b};
			FEP_FN_XOR:  wide = {1'b0, a ^ b};
			FEP_FN_CPL:  wide = {1'b0, ~a};
			FEP_FN_RR:   wide = {a[0], a[0], a[FEP_DATA_W-1:1]};
			FEP_FN_RL:   wide = {a[FEP_DATA_W-1], a[FEP_DATA_W-2:0], a[FEP_DATA_W-1]};
			FEP_FN_INC:  wide = {1'b0, a} + 9'h001;
			FEP_FN_DEC:  wide = {1'b0, a} - 9'h001;
			FEP_FN_PASS: wide = {1'b0, b};
			default:     wide = {1'b0, a};
		endcase
		result = wide[FEP_DATA_W-1:0];
		carry  = wide[FEP_DATA_W];
		zero   = (wide[FEP_DATA_W-1:0] == '0);
	end

endmodule

// >>> testbench/fep_pm_model.sv
/*
 * program memory model: one 16-bit word per address, answering combinationally.
 * assumes the bench loads mem before reset is released; while pm_rd is low the bus shows the inverse.
 */
`timescale 1ns/100ps
module fep_pm_model import fep_pkg::*; #(
	parameter int PC_W = FEP_PC_W_DEF
) (
	// fetch request
	input  wire logic [PC_W-1:0]  pm_addr,
	input  wire logic             pm_rd,
	// instruction word
	output logic [FEP_INSTR_W-1:0] pm_data
);
	// ============================================================
	// storage and read path
	logic [FEP_INSTR_W-1:0] mem [0:(1<<PC_W)-1];

	// undriven bus shows a changed value so a late sample cannot pass by chance
	assign pm_data = pm_rd ? mem[pm_addr] : ~mem[pm_addr];
endmodule

// >>> testbench/four_phase_fetch_execute_pipeline_tb.sv
/*
 * bench of the four-phase pipeline: program walk with branch, skip, page writes, alu ops, source select.
 * assumes fep_pipe with PC_W 11 and the fep_pm_model beside it.
 */
`timescale 1ns/100ps
module four_phase_fetch_execute_pipeline_tb;
	import fep_pkg::*;
	// ============================================================
	// signals
	logic                   clk_sys     = 1'b0;
	logic                   nrst        = 1'b0;
	logic [2:0]             ticks       = 3'h0;
	fep_src_type            clk_src     = FEP_SRC_CRYSTAL;
	logic [10:0]            pm_addr;
	logic                   pm_rd;
	logic [FEP_INSTR_W-1:0] pm_data;
	fep_phase_type          phase;
	logic [7:0]             acc;
	fep_status_type         status;
	int                     fails       = 0;
	int                     checks_done = 0;
	int                     cycles      = 0;
	// {pm_addr, acc, retire/branch/skip} after each instruction cycle end
	logic [23:0] exp_tab [0:23] = '{24'h001000, 24'h002054, 24'h003084, 24'h006086, 24'h007080, 24'h008084,
		24'h009004, 24'h00A005, 24'h00B000, 24'h00C104, 24'h010106, 24'h011100, 24'h012114, 24'h100116,
		24'h101110, 24'h102F14, 24'h1F1F16, 24'h1F2F10, 24'h1F3F04, 24'h1F4C34, 24'h1F53C4, 24'h1F6784,
		24'h1F73C4, 24'h1F83D4};

	// ============================================================
	// design, memory, clock, timeout
	fep_pipe #(.PC_W(11)) u_dut (.clk_sys(clk_sys), .nrst(nrst), .crystal_oscillator(ticks[0]),
		.fast_internal_rc(ticks[1]), .slow_internal_rc(ticks[2]), .clk_src(clk_src), .pm_addr(pm_addr),
		.pm_rd(pm_rd), .pm_data(pm_data), .phase(phase), .acc(acc), .status(status));
	fep_pm_model #(.PC_W(11)) u_mem (.pm_addr(pm_addr), .pm_rd(pm_rd), .pm_data(pm_data));

	always #12.5 clk_sys = ~clk_sys;

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			report_and_stop();
		end
	end

	// ============================================================
	// shared tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic do_reset();
		@(posedge clk_sys);
		nrst <= 1'b0;
		ticks <= 3'h0;
		repeat (20) @(posedge clk_sys);
		#1;
		chk(16'(phase), 16'(FEP_PH_RESET), "reset phase");
		chk({pm_rd, 4'h0, pm_addr}, 16'h8000, "reset fetch");
		chk({acc, 3'h0, status}, 16'h0000, "reset state");
		@(posedge clk_sys);
		nrst <= 1'b1;
	endtask

	// one instruction cycle from phase two to phase two of the next
	task automatic one_cycle(input logic [23:0] e);
		@(posedge clk_sys);
		#1 chk(16'(phase), 16'h0004, "phase three");
		@(posedge clk_sys);
		#1 chk(16'(phase), 16'h0008, "phase four");
		@(posedge clk_sys);
		#1 chk({pm_rd, 11'h000, phase}, 16'h8001, "phase one");
		chk(16'(pm_addr), 16'(e[22:12]), "fetch address");
		chk(16'(acc), 16'(e[11:4]), "accumulator");
		chk(16'(status[4:2]), 16'(e[2:0]), "retire pulses");
		@(posedge clk_sys);
		#1 chk({pm_rd, 11'h000, phase}, 16'h0002, "phase two");
		chk(16'(status[4:2]), 16'h0000, "pulse width");
	endtask

	// ============================================================
	// scenarios
	task automatic run_program();
		for (int i = 0; i < 2048; i++) u_mem.mem[i] = 16'h0000;
		u_mem.mem[0] = 16'h1A05;
		u_mem.mem[1] = 16'h1003;
		u_mem.mem[2] = 16'h2006;
		u_mem.mem[3] = 16'h1AFF;
		u_mem.mem[6] = 16'h4000;
		u_mem.mem[7] = 16'h1200;
		u_mem.mem[8] = 16'h4000;
		u_mem.mem[9] = 16'h1A77;
		u_mem.mem[10] = 16'h1A10;
		u_mem.mem[11] = 16'h5000;
		u_mem.mem[12] = 16'h1AEE;
		u_mem.mem[16] = 16'h1800;
		u_mem.mem[17] = 16'h3100;
		u_mem.mem[256] = 16'h1120;
		u_mem.mem[257] = 16'h5000;
		u_mem.mem[258] = 16'h1AEE;
		u_mem.mem[497] = 16'h1900;
		u_mem.mem[498] = 16'h1433;
		u_mem.mem[499] = 16'h1500;
		u_mem.mem[500] = 16'h1700;
		u_mem.mem[501] = 16'h1600;
		u_mem.mem[502] = 16'h1301;
		do_reset();
		ticks <= 3'h1;
		@(posedge clk_sys);
		#1 chk(16'(phase), 16'h0002, "first tick");
		for (int i = 0; i < 24; i++) begin
			one_cycle(exp_tab[i]);
			if (i == 6) chk(16'(status[1:0]), 16'h0001, "and zero flag");
			if (i == 15) chk(16'(status[1:0]), 16'h0002, "sub borrow flag");
		end
	endtask

	task automatic check_sources();
		logic [2:0] oh;
		for (int s = 0; s < 4; s++) begin
			oh = (s < 3) ? 3'(1 << s) : 3'h0;
			do_reset();
			clk_src <= fep_src_type'(s[1:0]);
			ticks <= ~oh;
			repeat (2) begin
				@(posedge clk_sys);
				#1 chk(16'(phase), 16'h0001, "foreign tick");
			end
			@(posedge clk_sys);
			ticks <= oh;
			#1 chk(16'(phase), 16'h0001, "foreign tick");
			@(posedge clk_sys);
			ticks <= 3'h0;
			#1 chk(16'(phase), (s < 3) ? 16'h0002 : 16'h0001, "selected tick");
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		run_program();
		check_sources();
		report_and_stop();
	end
endmodule
